// ### shared/buck_pkg.sv
// Shared constants, register map and carrier types of the buck drive control block.
package buck_pkg;

   localparam int unsigned REG_ADDR_W = 3;
   localparam int unsigned REG_DATA_W = 8;

   // Register map, one byte per address.
   localparam logic [REG_ADDR_W-1:0] ADDR_DEAD_TIME = 3'h0;
   localparam logic [REG_ADDR_W-1:0] ADDR_VREF_COARSE = 3'h1;
   localparam logic [REG_ADDR_W-1:0] ADDR_VREF_FINE = 3'h2;
   localparam logic [REG_ADDR_W-1:0] ADDR_UV_LEVEL = 3'h3;
   localparam logic [REG_ADDR_W-1:0] ADDR_OV_LEVEL = 3'h4;
   localparam logic [REG_ADDR_W-1:0] ADDR_PERIPH_EN = 3'h5;
   localparam logic [REG_ADDR_W-1:0] ADDR_BLOCK_EN = 3'h6;
   localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 3'h7;

   localparam logic [REG_DATA_W-1:0] RESET_BYTE = 8'h00;

   // Field positions.
   localparam int unsigned HS_CODE_LSB = 4;
   localparam int unsigned LS_CODE_LSB = 0;
   localparam int unsigned DT_CODE_W = 4;
   localparam int unsigned FINE_W = 5;
   localparam int unsigned VREF_EN_BIT = 7;
   localparam int unsigned DE_SEL_BIT = 7;
   localparam int unsigned DRV_STR_BIT = 6;
   localparam int unsigned HS_BYP_BIT = 5;
   localparam int unsigned LS_BYP_BIT = 4;
   localparam int unsigned PDN_BIT = 3;
   localparam int unsigned PUP_BIT = 2;
   localparam int unsigned UV_ACCEL_BIT = 1;
   localparam int unsigned OV_ACCEL_BIT = 0;
   localparam int unsigned OV_DET_BIT = 7;
   localparam int unsigned UV_DET_BIT = 6;
   localparam int unsigned UV_FLAG_BIT = 0;
   localparam int unsigned OV_FLAG_BIT = 1;

   // Dead time figures in nanoseconds and the clock rate.
   localparam logic [7:0] HS_DT_BASE_NS = 8'h0b;
   localparam logic [7:0] LS_DT_BASE_NS = 8'h04;
   localparam logic [7:0] DT_STEP_NS = 8'h04;
   localparam int unsigned CLK_FREQ_MHZ = 50;
   localparam logic [7:0] CLK_PERIOD_NS = 8'(1000 / CLK_FREQ_MHZ);

   // Reference steps in microvolts.
   localparam int unsigned VREF_UV_W = 22;
   localparam logic [VREF_UV_W-1:0] COARSE_STEP_UV = 22'h003a98;
   localparam logic [VREF_UV_W-1:0] FINE_STEP_UV = 22'h000334;

   typedef struct packed {
      logic en;
      logic [7:0] coarse;
      logic [FINE_W-1:0] fine;
   } vref_s;

   typedef struct packed {
      logic high;
      logic low;
   } gate_drive_s;

   typedef enum logic [2:0] {
      ST_WAIT = 3'h0,
      ST_HS_DEAD = 3'h1,
      ST_HS_ON = 3'h3,
      ST_LS_DEAD = 3'h2,
      ST_LS_ON = 3'h6,
      ST_FAULT = 3'h4
   } drive_state_e;

endpackage

// ### src/buck_drive_ctrl.sv
// Gate drive sequencing, reference setting and output voltage monitor of a buck controller.
//
// Notes on behaviour
// - High-side dead-time code in bits 7:4, 11 ns plus 4 ns per step.
// - Low-side dead-time code in bits 3:0, 4 ns plus 4 ns per step.
// - Dead time is added to a turn-on edge only while its bypass bit is clear.
// - Reference is coarse code times 15 mV plus fine code times 0.82 mV.
// - Software loads 5-bit fine code; bits 6:5 of that register read zero.
// - Reference setting applies only while its enable bit is one.
// - Undervoltage flag sets when output is below threshold, sticks until software clears.
// - Overvoltage flag sets when output is above threshold, sticks until software clears.
// - Diode emulation ends low drive at zero crossing; both low until next cycle.
// - Synchronous rectification keeps low drive high until next cycle starts.
// - Peripheral enable bit 7 selects diode emulation, else synchronous rectification.
// - Bit 6 set selects 1A high-side drive strength, clear selects 2A.
// - Bit 3 enables negative sense pull-down, bit 2 positive sense pull-up.
// - Undervoltage accelerator drives both gates low on undervoltage.
// - Overvoltage accelerator drives both gates low on overvoltage.
// - A cleared detector enable disables that detector and ignores its threshold.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
module buck_drive_ctrl
   import buck_pkg::*;
#(
   parameter int unsigned DT_CNT_W = 3
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [REG_ADDR_W-1:0] addr_i,
   input wire logic [REG_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [REG_DATA_W-1:0] rdata_o,
   input wire logic pwm_i,
   input wire logic zero_cross_i,
   input wire logic [7:0] vout_level_i,
   output gate_drive_s gate_o,
   output logic high_drive_1a_o,
   output logic neg_sense_pulldown_en_o,
   output logic pos_sense_pullup_en_o,
   output vref_s vref_code_o,
   output logic [VREF_UV_W-1:0] vref_uv_o
);

   // The longest dead time must fit the counter; the high side has the longest one.
   localparam logic [7:0] MAX_DT_NS = HS_DT_BASE_NS + DT_STEP_NS * 8'((1 << DT_CODE_W) - 1);
   localparam logic [7:0] MAX_DT_CYC = (MAX_DT_NS + CLK_PERIOD_NS - 8'h01) / CLK_PERIOD_NS;
   if (32'(MAX_DT_CYC) >= (32'h1 << DT_CNT_W)) begin : g_bad_width
      $error("DT_CNT_W too small for the longest dead time");
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] dead_time_ctrl_q;
   logic [7:0] vref_coarse_ctrl_q;
   logic [7:0] vref_fine_ctrl_q;
   logic [7:0] undervoltage_level_q;
   logic [7:0] overvoltage_level_q;
   logic [7:0] analog_periph_enable_q;
   logic [7:0] analog_block_enable_reg_q;
   logic undervoltage_flag_q;
   logic overvoltage_flag_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   wire wr_dead = wr_i && (addr_i == ADDR_DEAD_TIME);
   wire wr_coarse = wr_i && (addr_i == ADDR_VREF_COARSE);
   wire wr_fine = wr_i && (addr_i == ADDR_VREF_FINE);
   wire wr_uv = wr_i && (addr_i == ADDR_UV_LEVEL);
   wire wr_ov = wr_i && (addr_i == ADDR_OV_LEVEL);
   wire wr_pe = wr_i && (addr_i == ADDR_PERIPH_EN);
   wire wr_be = wr_i && (addr_i == ADDR_BLOCK_EN);
   wire wr_status = wr_i && (addr_i == ADDR_STATUS);

   // Unimplemented fine bits are never stored, so they always read zero.
   wire [7:0] fine_wr_val = {wdata_i[VREF_EN_BIT], 2'h0, wdata_i[FINE_W-1:0]};

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dead_time_ctrl_q <= RESET_BYTE;
         vref_coarse_ctrl_q <= RESET_BYTE;
         vref_fine_ctrl_q <= RESET_BYTE;
         undervoltage_level_q <= RESET_BYTE;
         overvoltage_level_q <= RESET_BYTE;
         analog_periph_enable_q <= RESET_BYTE;
         analog_block_enable_reg_q <= RESET_BYTE;
      end else begin
         if (wr_dead) dead_time_ctrl_q <= wdata_i;
         if (wr_coarse) vref_coarse_ctrl_q <= wdata_i;
         if (wr_fine) vref_fine_ctrl_q <= fine_wr_val;
         if (wr_uv) undervoltage_level_q <= wdata_i;
         if (wr_ov) overvoltage_level_q <= wdata_i;
         if (wr_pe) analog_periph_enable_q <= wdata_i;
         if (wr_be) analog_block_enable_reg_q <= wdata_i;
      end
   end

   // Field decode.
   wire [DT_CODE_W-1:0] high_side_delay_code = dead_time_ctrl_q[HS_CODE_LSB +: DT_CODE_W];
   wire [DT_CODE_W-1:0] low_side_delay_code = dead_time_ctrl_q[LS_CODE_LSB +: DT_CODE_W];
   wire diode_emulation_select = analog_periph_enable_q[DE_SEL_BIT];
   wire high_side_delay_bypass = analog_periph_enable_q[HS_BYP_BIT];
   wire low_side_delay_bypass = analog_periph_enable_q[LS_BYP_BIT];
   wire undervoltage_accel_en = analog_periph_enable_q[UV_ACCEL_BIT];
   wire overvoltage_accel_en = analog_periph_enable_q[OV_ACCEL_BIT];
   wire overvoltage_detect_en = analog_block_enable_reg_q[OV_DET_BIT];
   wire undervoltage_detect_en = analog_block_enable_reg_q[UV_DET_BIT];
   wire vref_enable = vref_fine_ctrl_q[VREF_EN_BIT];

   wire [7:0] status_val = {6'h00, overvoltage_flag_q, undervoltage_flag_q};

   always_comb begin
      rdata_d = RESET_BYTE;
      if (rd_i) begin
         unique case (addr_i)
            ADDR_DEAD_TIME: rdata_d = dead_time_ctrl_q;
            ADDR_VREF_COARSE: rdata_d = vref_coarse_ctrl_q;
            ADDR_VREF_FINE: rdata_d = vref_fine_ctrl_q;
            ADDR_UV_LEVEL: rdata_d = undervoltage_level_q;
            ADDR_OV_LEVEL: rdata_d = overvoltage_level_q;
            ADDR_PERIPH_EN: rdata_d = analog_periph_enable_q;
            ADDR_BLOCK_EN: rdata_d = analog_block_enable_reg_q;
            ADDR_STATUS: rdata_d = status_val;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= RESET_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Output voltage monitor and sticky flags.

   // A disabled detector never fires, whatever its threshold holds.
   wire uv_cond = undervoltage_detect_en && (vout_level_i < undervoltage_level_q);
   wire ov_cond = overvoltage_detect_en && (vout_level_i > overvoltage_level_q);
   wire uv_clr = wr_status && wdata_i[UV_FLAG_BIT];
   wire ov_clr = wr_status && wdata_i[OV_FLAG_BIT];

   // A new event in the clearing cycle wins, so no crossing is lost.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         undervoltage_flag_q <= 1'b0;
         overvoltage_flag_q <= 1'b0;
      end else begin
         undervoltage_flag_q <= uv_cond || (undervoltage_flag_q && !uv_clr);
         overvoltage_flag_q <= ov_cond || (overvoltage_flag_q && !ov_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Reference, strength and sense pull controls.

   vref_s vref_d;
   logic [VREF_UV_W-1:0] vref_uv_d;
   vref_s vref_q;
   logic [VREF_UV_W-1:0] vref_uv_q;
   logic high_drive_1a_q;
   logic pulldown_q;
   logic pullup_q;

   assign vref_d.en = vref_enable;
   assign vref_d.coarse = vref_enable ? vref_coarse_ctrl_q : 8'h00;
   assign vref_d.fine = vref_enable ? vref_fine_ctrl_q[FINE_W-1:0] : 5'h00;
   assign vref_uv_d = COARSE_STEP_UV * VREF_UV_W'(vref_d.coarse)
      + FINE_STEP_UV * VREF_UV_W'(vref_d.fine);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         vref_q <= '0;
         vref_uv_q <= '0;
         high_drive_1a_q <= 1'b0;
         pulldown_q <= 1'b0;
         pullup_q <= 1'b0;
      end else begin
         vref_q <= vref_d;
         vref_uv_q <= vref_uv_d;
         high_drive_1a_q <= analog_periph_enable_q[DRV_STR_BIT];
         pulldown_q <= analog_periph_enable_q[PDN_BIT];
         pullup_q <= analog_periph_enable_q[PUP_BIT];
      end
   end

   assign vref_code_o = vref_q;
   assign vref_uv_o = vref_uv_q;
   assign high_drive_1a_o = high_drive_1a_q;
   assign neg_sense_pulldown_en_o = pulldown_q;
   assign pos_sense_pullup_en_o = pullup_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic pwm_meta_q;
   logic pwm_s_q;
   logic pwm_prev_q;
   logic zc_meta_q;
   logic zc_s_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwm_meta_q <= 1'b0;
         pwm_s_q <= 1'b0;
         pwm_prev_q <= 1'b0;
         zc_meta_q <= 1'b0;
         zc_s_q <= 1'b0;
      end else begin
         pwm_meta_q <= pwm_i;
         pwm_s_q <= pwm_meta_q;
         pwm_prev_q <= pwm_s_q;
         zc_meta_q <= zero_cross_i;
         zc_s_q <= zc_meta_q;
      end
   end

   wire cycle_start = pwm_s_q && !pwm_prev_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Dead time lengths, least times rounded up to whole clock cycles.

   wire [7:0] hs_ns = HS_DT_BASE_NS + DT_STEP_NS * {4'h0, high_side_delay_code};
   wire [7:0] ls_ns = LS_DT_BASE_NS + DT_STEP_NS * {4'h0, low_side_delay_code};
   wire [7:0] hs_div = (hs_ns + CLK_PERIOD_NS - 8'h01) / CLK_PERIOD_NS;
   wire [7:0] ls_div = (ls_ns + CLK_PERIOD_NS - 8'h01) / CLK_PERIOD_NS;
   wire [DT_CNT_W-1:0] hs_cyc = hs_div[DT_CNT_W-1:0];
   wire [DT_CNT_W-1:0] ls_cyc = ls_div[DT_CNT_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////////////
   // Drive sequencer.

   drive_state_e state_q;
   drive_state_e state_d;
   logic [DT_CNT_W-1:0] cnt_q;
   logic [DT_CNT_W-1:0] cnt_d;
   // The drives are taken from the next state, so they add no edge of delay of their own.
   gate_drive_s gate_q;

   wire fault = (uv_cond && undervoltage_accel_en) || (ov_cond && overvoltage_accel_en);
   wire cnt_done = (cnt_q == '0);
   // With bypass set the turn-on follows the other turn-off on the same edge.
   wire drive_state_e hs_entry = high_side_delay_bypass ? ST_HS_ON : ST_HS_DEAD;
   wire drive_state_e ls_entry = low_side_delay_bypass ? ST_LS_ON : ST_LS_DEAD;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (fault) begin
         state_d = ST_FAULT;
      end else begin
         unique case (state_q)
            ST_WAIT: if (cycle_start) state_d = hs_entry;
            ST_HS_DEAD: if (cnt_done) state_d = ST_HS_ON;
            ST_HS_ON: if (!pwm_s_q) state_d = ls_entry;
            ST_LS_DEAD: begin
               if (cycle_start) state_d = hs_entry;
               else if (cnt_done) state_d = ST_LS_ON;
            end
            ST_LS_ON: begin
               if (cycle_start) state_d = hs_entry;
               else if (diode_emulation_select && zc_s_q) state_d = ST_WAIT;
            end
            ST_FAULT: state_d = ST_WAIT;
         endcase
      end
      if (state_d == ST_HS_DEAD && state_q != ST_HS_DEAD) begin
         cnt_d = hs_cyc - 1'b1;
      end else if (state_d == ST_LS_DEAD && state_q != ST_LS_DEAD) begin
         cnt_d = ls_cyc - 1'b1;
      end else if (!cnt_done) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_WAIT;
         cnt_q <= '0;
         gate_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         gate_q.high <= (state_d == ST_HS_ON);
         gate_q.low <= (state_d == ST_LS_ON);
      end
   end

   assign gate_o = gate_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   // Counts both-low cycles and saturates, so a long idle gap never wraps to a short one.
   logic [3:0] low_run_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_run_q <= '0;
      end else if (gate_q.high || gate_q.low) begin
         low_run_q <= '0;
      end else if (low_run_q != 4'hf) begin
         low_run_q <= low_run_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_no_overlap: assert property (!(gate_q.high && gate_q.low))
      else $error("both gate drives high");
   a_hs_dead_gap: assert property ($rose(gate_q.high) && !$past(high_side_delay_bypass, 1)
      && $stable(hs_cyc) |-> low_run_q >= 4'(hs_cyc))
      else $error("high-side turn-on before its dead time");
   a_ls_dead_gap: assert property ($rose(gate_q.low) && !$past(low_side_delay_bypass, 1)
      && $stable(ls_cyc) |-> low_run_q >= 4'(ls_cyc))
      else $error("low-side turn-on before its dead time");
   a_uv_flag_set: assert property (uv_cond |=> undervoltage_flag_q)
      else $error("undervoltage flag not set");
   a_ov_flag_hold: assert property (overvoltage_flag_q && !ov_clr |=> overvoltage_flag_q)
      else $error("overvoltage flag dropped without a clear");
   a_fault_gates_off: assert property (fault |=> !gate_q.high && !gate_q.low)
      else $error("gate drive high during accelerated fault");
   a_vref_gated: assert property (!vref_enable |=> vref_uv_o == '0 && !vref_code_o.en)
      else $error("reference applied while disabled");
   a_fine_reads_zero: assert property (rd_i && addr_i == ADDR_VREF_FINE
      |=> rdata_o[6:5] == 2'h0)
      else $error("unimplemented fine bits read nonzero");
   a_de_idle: assert property (state_q == ST_LS_ON && diode_emulation_select && zc_s_q
      && !cycle_start && !fault |=> !gate_q.low ##1 (state_q != ST_LS_ON))
      else $error("diode emulation did not end low drive");
   a_sync_hold: assert property (state_q == ST_LS_ON && !diode_emulation_select
      && !cycle_start && !fault |=> gate_q.low)
      else $error("synchronous rectification released low drive early");
   a_uv_ignored: assert property (!undervoltage_detect_en |-> !uv_cond)
      else $error("disabled undervoltage detector fired");
   a_strength_follows: assert property (wr_pe |=> ##1
      high_drive_1a_o == $past(wdata_i[DRV_STR_BIT], 2))
      else $error("drive strength not applied");
   a_ov_flag_set: assert property (ov_cond |=> overvoltage_flag_q)
      else $error("overvoltage flag not set");
   a_uv_flag_hold: assert property (undervoltage_flag_q && !uv_clr |=> undervoltage_flag_q)
      else $error("undervoltage flag dropped without a clear");
   a_uv_flag_clear: assert property (uv_clr && !uv_cond |=> !undervoltage_flag_q)
      else $error("undervoltage flag not cleared");
   a_ov_ignored: assert property (!overvoltage_detect_en && !overvoltage_flag_q
      |=> !overvoltage_flag_q)
      else $error("disabled overvoltage detector set its flag");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
      else $error("read data present without a read");
   a_pull_follows: assert property (wr_pe |=> ##1
      neg_sense_pulldown_en_o == $past(wdata_i[PDN_BIT], 2)
      && pos_sense_pullup_en_o == $past(wdata_i[PUP_BIT], 2))
      else $error("sense pull controls not applied");
   a_vref_applied: assert property (vref_enable |=> vref_code_o.en
      && vref_code_o.coarse == $past(vref_coarse_ctrl_q))
      else $error("reference not applied while enabled");
   a_wait_gates_low: assert property (state_q == ST_WAIT && !cycle_start
      |=> !gate_q.high && !gate_q.low)
      else $error("drive raised while waiting for a cycle start");

   c_bypassed_turn_on: cover property (high_side_delay_bypass && $rose(gate_q.high));
   c_de_idle: cover property (state_q == ST_LS_ON ##1 state_q == ST_WAIT);
   c_fault_stop: cover property (gate_q.high ##1 state_q == ST_FAULT);
   c_flag_clear_race: cover property (uv_cond && uv_clr);
   c_sync_restart: cover property (state_q == ST_LS_ON ##1 state_q == ST_HS_DEAD);

endmodule

// ### verification/fet_model.sv
// Behavioural model of the external high-side and low-side power switches.
`timescale 1ns/100ps
module fet_model
   import buck_pkg::*;
#(
   parameter int unsigned ZC_CYCLES = 4
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire gate_drive_s gate_i,
   output logic zero_cross_o,
   output logic [7:0] overlap_o
);
   logic [7:0] low_on_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Inductor current decays while the low-side switch conducts, so the switch
   // voltage reaches about zero after a fixed time. The comparator keeps reporting
   // zero even when the drive ignores it, as a real one would.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_on_q <= 8'h00;
         zero_cross_o <= 1'b0;
         overlap_o <= 8'h00;
      end else begin
         if (gate_i.high) begin
            low_on_q <= 8'h00;
            zero_cross_o <= 1'b0;
         end else if (gate_i.low && low_on_q < 8'(ZC_CYCLES)) begin
            low_on_q <= low_on_q + 8'h01;
         end else if (gate_i.low) begin
            zero_cross_o <= 1'b1;
         end
         // Shoot-through would destroy real switches; count every such cycle.
         if (gate_i.high && gate_i.low) begin
            overlap_o <= overlap_o + 8'h01;
         end
      end
   end
endmodule

// ### verification/tb_top.sv
// Self-checking testbench of the buck drive control block.
`timescale 1ns/100ps
module tb_top
   import buck_pkg::*;
;
   localparam logic [7:0] WV [7] = '{8'ha5, 8'h3c, 8'hff, 8'h40, 8'hc0, 8'h4c, 8'h3f};
   localparam logic [7:0] PE_V [3] = '{8'h02, 8'h01, 8'h00};
   localparam logic [7:0] VO_V [3] = '{8'h10, 8'hf0, 8'h10};
   localparam logic [1:0] GX_V [3] = '{2'h0, 2'h0, 2'h2};
   localparam logic [7:0] HS_MAX_NS = HS_DT_BASE_NS + DT_STEP_NS * 8'h0f;
   localparam logic [7:0] LS_MAX_NS = LS_DT_BASE_NS + DT_STEP_NS * 8'h0f;
   logic clk_i;
   logic arst_n_i;
   logic [REG_ADDR_W-1:0] addr_i;
   logic [REG_DATA_W-1:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [REG_DATA_W-1:0] rdata_o;
   logic pwm_i;
   logic zero_cross_i;
   logic [7:0] vout_level_i;
   gate_drive_s gate_o;
   gate_drive_s prev_gate;
   logic high_drive_1a_o;
   logic neg_sense_pulldown_en_o;
   logic pos_sense_pullup_en_o;
   vref_s vref_code_o;
   logic [VREF_UV_W-1:0] vref_uv_o;
   logic [7:0] overlap;
   int n_mismatch = 0;
   int num_checks = 0;
   int gap_cnt = 0;
   int hs_gap = 0;
   int ls_gap = 0;

   buck_drive_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_i(pwm_i), .zero_cross_i(zero_cross_i),
      .vout_level_i(vout_level_i), .gate_o(gate_o), .high_drive_1a_o(high_drive_1a_o),
      .neg_sense_pulldown_en_o(neg_sense_pulldown_en_o),
      .pos_sense_pullup_en_o(pos_sense_pullup_en_o), .vref_code_o(vref_code_o),
      .vref_uv_o(vref_uv_o));

   fet_model fets (.clk_i(clk_i), .arst_n_i(arst_n_i), .gate_i(gate_o),
      .zero_cross_o(zero_cross_i), .overlap_o(overlap));

   ////////////////////////////////////////////////////////////////////////////////
   initial clk_i = 1'b0;
   always #10 clk_i = ~clk_i;

   // Both-low cycles before each turn-on, sampled mid-cycle where outputs are settled.
   always @(negedge clk_i) begin
      if (!gate_o.high && !gate_o.low) begin
         gap_cnt++;
      end else begin
         if (gate_o.high && !prev_gate.high) hs_gap = gap_cnt;
         if (gate_o.low && !prev_gate.low) ls_gap = gap_cnt;
         gap_cnt = 0;
      end
      prev_gate = gate_o;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] dead_n(input logic [7:0] ns);
      return 32'((ns + CLK_PERIOD_NS - 8'h01) / CLK_PERIOD_NS);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(32'(rdata_o), 32'(exp));
   endtask

   task automatic set_vout(input logic [7:0] v);
      @(posedge clk_i);
      vout_level_i <= v;
      repeat (3) @(posedge clk_i);
   endtask

   // The sync stage delays both edges alike, so the gaps are not skewed by it.
   task automatic pwm_cycle(input int hi, input int lo);
      @(posedge clk_i);
      pwm_i <= 1'b1;
      repeat (hi) @(posedge clk_i);
      pwm_i <= 1'b0;
      repeat (lo) @(posedge clk_i);
      #1;
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      #1_000_000;
      $display("timeout");
      n_mismatch++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      pwm_i = 1'b0;
      vout_level_i = 8'h80;
      prev_gate = '0;
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int a = 0; a < 8; a++) rd_chk(3'(a), RESET_BYTE);
      $display("test reset_values done");

      for (int a = 0; a < 7; a++) wr(3'(a), WV[a]);
      for (int a = 0; a < 7; a++) rd_chk(3'(a), (a == 2) ? 8'h9f : WV[a]);
      rd_chk(ADDR_STATUS, 8'h00);
      chk(32'(high_drive_1a_o), 32'h1);
      chk(32'(neg_sense_pulldown_en_o), 32'h1);
      chk(32'(pos_sense_pullup_en_o), 32'h1);
      chk(32'(vref_code_o), 32'({1'b1, 8'h3c, 5'h1f}));
      chk(32'(vref_uv_o), 32'(COARSE_STEP_UV) * 32'h3c + 32'(FINE_STEP_UV) * 32'h1f);
      wr(ADDR_PERIPH_EN, 8'h08);
      wr(ADDR_VREF_FINE, 8'h1f);
      repeat (2) @(posedge clk_i);
      #1;
      chk(32'(high_drive_1a_o), 32'h0);
      chk(32'({neg_sense_pulldown_en_o, pos_sense_pullup_en_o}), 32'h2);
      chk(32'(vref_code_o), 32'h0);
      chk(32'(vref_uv_o), 32'h0);
      rd_chk(ADDR_VREF_FINE, 8'h1f);
      $display("test registers done");

      // Two cycles per code: the second starts from a conducting low side.
      for (int k = 0; k < 16; k++) begin
         wr(ADDR_DEAD_TIME, {4'(k), 4'(k)});
         pwm_cycle(12, 12);
         pwm_cycle(12, 12);
         chk(32'(hs_gap), dead_n(HS_DT_BASE_NS + DT_STEP_NS * 8'(k)));
         chk(32'(ls_gap), dead_n(LS_DT_BASE_NS + DT_STEP_NS * 8'(k)));
         chk(32'(gate_o.low), 32'h1);
      end
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_PERIPH_EN, (b == 1) ? 8'h10 : 8'h20);
         pwm_cycle(12, 12);
         pwm_cycle(12, 12);
         chk(32'(hs_gap), (b == 1) ? dead_n(HS_MAX_NS) : 32'h0);
         chk(32'(ls_gap), (b == 1) ? 32'h0 : dead_n(LS_MAX_NS));
      end
      $display("test dead_time done");

      wr(ADDR_PERIPH_EN, 8'h80);
      pwm_cycle(12, 12);
      pwm_cycle(12, 12);
      chk(32'(ls_gap), dead_n(LS_MAX_NS));
      repeat (4) @(posedge clk_i);
      #1;
      chk(32'(gate_o), 32'h0);
      $display("test diode_emulation done");

      wr(ADDR_PERIPH_EN, 8'h00);
      set_vout(8'h10);
      rd_chk(ADDR_STATUS, 8'h00);
      set_vout(8'hf0);
      rd_chk(ADDR_STATUS, 8'h00);
      wr(ADDR_BLOCK_EN, 8'hc0);
      rd_chk(ADDR_STATUS, 8'h02);
      set_vout(8'hc0);
      rd_chk(ADDR_STATUS, 8'h02);
      wr(ADDR_STATUS, 8'h02);
      rd_chk(ADDR_STATUS, 8'h00);
      set_vout(8'h40);
      rd_chk(ADDR_STATUS, 8'h00);
      set_vout(8'h3f);
      set_vout(8'h80);
      rd_chk(ADDR_STATUS, 8'h01);
      wr(ADDR_STATUS, 8'h01);
      rd_chk(ADDR_STATUS, 8'h00);
      $display("test monitor done");

      for (int f = 0; f < 3; f++) begin
         wr(ADDR_PERIPH_EN, PE_V[f]);
         @(posedge clk_i);
         pwm_i <= 1'b1;
         repeat (10) @(posedge clk_i);
         vout_level_i <= VO_V[f];
         repeat (2) @(posedge clk_i);
         #1;
         chk(32'(gate_o), 32'(GX_V[f]));
         @(posedge clk_i);
         vout_level_i <= 8'h80;
         repeat (4) @(posedge clk_i);
         #1;
         chk(32'(gate_o), 32'(GX_V[f]));
         @(posedge clk_i);
         pwm_i <= 1'b0;
         repeat (12) @(posedge clk_i);
         wr(ADDR_STATUS, 8'h03);
      end
      #1;
      chk(32'(overlap), 32'h0);
      $display("test accelerators done");
      end_sim();
   end
endmodule
